// ==== common/input_exponent_scaler_regs.vh ====
// Purpose: Register indices, field positions, reset values and constants for the scaler
// Assumes: Word index is the byte address divided by four
// Notes: Definitions only
`ifndef INPUT_EXPONENT_SCALER_REGS_VH
`define INPUT_EXPONENT_SCALER_REGS_VH

// ----------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------
`define IES_IDX_CTRL 10'h090
`define IES_IDX_SCALE 10'h092
`define IES_IDX_UPPER 10'h094
`define IES_IDX_LOWER 10'h095
`define IES_IDX_DWELL 10'h096
`define IES_IDX_STATUS 10'h097

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IES_ACTIVE_LSB 0
`define IES_ACTIVE_MSB 4
`define IES_IDLE_LSB 5
`define IES_IDLE_MSB 9
`define IES_INVERT_LSB 0
`define IES_INVERT_MSB 3
`define IES_WEIGHT_LSB 4
`define IES_WEIGHT_MSB 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IES_RST_SCALE 10'h000
`define IES_RST_CTRL 8'h00
`define IES_RST_UPPER 14'h1fff
`define IES_RST_LOWER 14'h1000
`define IES_RST_DWELL 16'h0010

// ----------------------------------------------------------------
// Shift arithmetic
// ----------------------------------------------------------------
`define IES_INV_BASE 5'h07

`endif

// ==== verilog/exponent_shifter.v ====
// Purpose: Combinational shift of one mantissa by exponent, invert, weight and scale
// Assumes: Scale already selected by the level indicator state
// Notes: Shift amount wraps modulo 32, only right shifts are ever applied
`timescale 1ns/1ps
`include "input_exponent_scaler_regs.vh"

module exponent_shifter #(
  parameter MANT_W = 14,
  parameter EXP_W = 3
) (
  // Sample
  input wire [MANT_W-1:0] mantissa_in,
  input wire [EXP_W-1:0] exponent_in,
  // Settings
  input wire [4:0] scale_in,
  input wire exponent_invert_in,
  input wire exponent_weight_in,
  // Result
  output wire [MANT_W-1:0] scaled_out
);

  // ----------------------------------------------------------------
  // Shift amount
  // ----------------------------------------------------------------
  // Five bit arithmetic gives the modulo 32 wrap for free
  function [4:0] shift_amount;
    input [EXP_W-1:0] e;
    input inv;
    input wgt;
    input [4:0] s;
    reg [4:0] ew;
    begin
      // Weight doubles the exponent; both forms are widened to five bits on purpose
      ew = wgt ? {{(4-EXP_W){1'b0}}, e, 1'b0} : {{(5-EXP_W){1'b0}}, e};
      if (inv) begin
        shift_amount = `IES_INV_BASE - ew + s;
      end else begin
        shift_amount = ew + s;
      end
    end
  endfunction

  wire [4:0] amount;
  assign amount = shift_amount(exponent_in, exponent_invert_in, exponent_weight_in, scale_in);

  // Arithmetic shift keeps the sign, low bits fall off
  assign scaled_out = $signed(mantissa_in) >>> amount;

endmodule

// ==== verilog/input_exponent_scaler.v ====
// Purpose: Four port input exponent scaler with level indicator and Wishbone registers
// Assumes: Port clocks arrive as one cycle sample strobes synchronous to sys_clk_in
// Notes: Scaled samples feed the resampling CIC filter, which lives elsewhere
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "input_exponent_scaler_regs.vh"

module input_exponent_scaler #(
  parameter MANT_W = 14,
  parameter EXP_W = 3,
  parameter DWELL_W = 16
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire sys_rst_in,
  // Sample strobes, one per pair of ports
  input wire port_clock_ab_in,
  input wire port_clock_cd_in,
  // Converter inputs, port A in the low slice
  input wire [4*MANT_W-1:0] mantissa_in,
  input wire [4*EXP_W-1:0] exponent_in,
  input wire [3:0] sample_valid_in,
  // Wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [11:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire wb_ack_out,
  // Scaled stream toward the resampling filter
  output wire [4*MANT_W-1:0] scaled_out,
  output wire [3:0] scaled_valid_out,
  // Level indicator lines
  output wire [3:0] level_indicator_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Magnitude of a two's complement mantissa, most negative saturates
  function [MANT_W-1:0] magnitude;
    input [MANT_W-1:0] m;
    reg [MANT_W-1:0] neg;
    begin
      neg = ~m + {{(MANT_W-1){1'b0}}, 1'b1};
      if (!m[MANT_W-1]) begin
        magnitude = m;
      end else if (neg[MANT_W-1]) begin
        magnitude = {1'b0, {(MANT_W-1){1'b1}}};
      end else begin
        magnitude = neg;
      end
    end
  endfunction

  // Byte lane merge for register writes
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      lane_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          lane_merge[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg [9:0] scale_q;
  reg [7:0] ctrl_q;
  reg [MANT_W-1:0] upper_thr_q;
  reg [MANT_W-1:0] lower_thr_q;
  reg [DWELL_W-1:0] dwell_q;
  reg [31:0] rdata_q;
  reg ack_q;
  reg [3:0] li_q;

  wire [9:0] word_idx;
  wire bus_req;
  wire bus_wr;

  // Word index; the printed offsets are word indices, not byte addresses
  assign word_idx = wb_adr_in[11:2];
  // Request is answered once, ack drops the cycle after it was given
  assign bus_req = wb_cyc_in && wb_stb_in && !ack_q;
  assign bus_wr = bus_req && wb_we_in;

  // Current values padded to a bus word, for merging partial writes
  wire [31:0] scale_word;
  wire [31:0] ctrl_word;
  wire [31:0] upper_word;
  wire [31:0] lower_word;
  wire [31:0] dwell_word;
  wire [31:0] status_word;
  assign scale_word = {22'h000000, scale_q};
  assign ctrl_word = {24'h000000, ctrl_q};
  assign upper_word = {{(32-MANT_W){1'b0}}, upper_thr_q};
  assign lower_word = {{(32-MANT_W){1'b0}}, lower_thr_q};
  assign dwell_word = {{(32-DWELL_W){1'b0}}, dwell_q};
  assign status_word = {28'h0000000, li_q};

  wire [31:0] scale_new;
  wire [31:0] ctrl_new;
  wire [31:0] upper_new;
  wire [31:0] lower_new;
  wire [31:0] dwell_new;
  assign scale_new = lane_merge(scale_word, wb_dat_in, wb_sel_in);
  assign ctrl_new = lane_merge(ctrl_word, wb_dat_in, wb_sel_in);
  assign upper_new = lane_merge(upper_word, wb_dat_in, wb_sel_in);
  assign lower_new = lane_merge(lower_word, wb_dat_in, wb_sel_in);
  assign dwell_new = lane_merge(dwell_word, wb_dat_in, wb_sel_in);

  // Register writes; unmapped indices are acked and ignored
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      scale_q <= `IES_RST_SCALE;
      ctrl_q <= `IES_RST_CTRL;
      upper_thr_q <= `IES_RST_UPPER;
      lower_thr_q <= `IES_RST_LOWER;
      dwell_q <= `IES_RST_DWELL;
    end else if (bus_wr) begin
      case (word_idx)
        `IES_IDX_SCALE: begin
          scale_q <= scale_new[9:0];
        end
        `IES_IDX_CTRL: begin
          ctrl_q <= ctrl_new[7:0];
        end
        `IES_IDX_UPPER: begin
          upper_thr_q <= upper_new[MANT_W-1:0];
        end
        `IES_IDX_LOWER: begin
          lower_thr_q <= lower_new[MANT_W-1:0];
        end
        `IES_IDX_DWELL: begin
          dwell_q <= dwell_new[DWELL_W-1:0];
        end
        default: begin
          scale_q <= scale_q;
        end
      endcase
    end
  end

  // Read data and acknowledge, one cycle after the request is seen
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_in) begin
        case (word_idx)
          `IES_IDX_SCALE: rdata_q <= scale_word;
          `IES_IDX_CTRL: rdata_q <= ctrl_word;
          `IES_IDX_UPPER: rdata_q <= upper_word;
          `IES_IDX_LOWER: rdata_q <= lower_word;
          `IES_IDX_DWELL: rdata_q <= dwell_word;
          `IES_IDX_STATUS: rdata_q <= status_word;
          default: rdata_q <= 32'h00000000;
        endcase
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  assign wb_dat_out = rdata_q;
  assign wb_ack_out = ack_q;

  // ----------------------------------------------------------------
  // Sample strobes
  // ----------------------------------------------------------------
  // A and B share one port clock, C and D the other
  wire [3:0] port_strobe;
  assign port_strobe = {port_clock_cd_in, port_clock_cd_in,
                        port_clock_ab_in, port_clock_ab_in};

  // Scale fields split out once so each port picks its own
  wire [4:0] active_level_scale;
  wire [4:0] idle_level_scale;
  assign active_level_scale = scale_q[`IES_ACTIVE_MSB:`IES_ACTIVE_LSB];
  assign idle_level_scale = scale_q[`IES_IDLE_MSB:`IES_IDLE_LSB];

  wire [3:0] exponent_invert;
  wire [3:0] exponent_weight;
  assign exponent_invert = ctrl_q[`IES_INVERT_MSB:`IES_INVERT_LSB];
  assign exponent_weight = ctrl_q[`IES_WEIGHT_MSB:`IES_WEIGHT_LSB];

  // ----------------------------------------------------------------
  // Level indicator per port
  // ----------------------------------------------------------------
  // The dwell counter runs on sample strobes, so its unit is one input sample
  reg [DWELL_W-1:0] dwell_cnt_q [0:3];
  integer p;
  integer q;
  // Magnitudes are plain nets, so the indicator process holds registers only
  wire [4*MANT_W-1:0] mag_all;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      li_q <= 4'h0;
      for (p = 0; p < 4; p = p + 1) begin
        dwell_cnt_q[p] <= {DWELL_W{1'b0}};
      end
    end else begin
      for (p = 0; p < 4; p = p + 1) begin
        if (port_strobe[p] && sample_valid_in[p]) begin
          if (mag_all[p*MANT_W +: MANT_W] >= upper_thr_q) begin
            li_q[p] <= 1'b1;
            dwell_cnt_q[p] <= dwell_q;
          end else if (li_q[p]) begin
            if (mag_all[p*MANT_W +: MANT_W] >= lower_thr_q) begin
              // Back above the low mark, restart the hold off
              dwell_cnt_q[p] <= dwell_q;
            end else if (dwell_cnt_q[p] == {DWELL_W{1'b0}}) begin
              li_q[p] <= 1'b0;
            end else begin
              dwell_cnt_q[p] <= dwell_cnt_q[p] - {{(DWELL_W-1){1'b0}}, 1'b1};
            end
          end
        end
      end
    end
  end

  assign level_indicator_out = li_q;

  // ----------------------------------------------------------------
  // Shifters and output stage
  // ----------------------------------------------------------------
  // Shift is combinational from the pins, result registered once
  wire [4*MANT_W-1:0] shifted;
  reg [4*MANT_W-1:0] scaled_q;
  reg [3:0] scaled_valid_q;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_port
      wire [4:0] sel_scale;
      // Scale follows the indicator state as the sample arrives
      assign sel_scale = li_q[g] ? active_level_scale : idle_level_scale;
      // Saturated magnitude for the threshold compare
      assign mag_all[g*MANT_W +: MANT_W] = magnitude(mantissa_in[g*MANT_W +: MANT_W]);

      exponent_shifter #(
        .MANT_W(MANT_W),
        .EXP_W(EXP_W)
      ) u_shift (
        .mantissa_in(mantissa_in[g*MANT_W +: MANT_W]),
        .exponent_in(exponent_in[g*EXP_W +: EXP_W]),
        .scale_in(sel_scale),
        .exponent_invert_in(exponent_invert[g]),
        .exponent_weight_in(exponent_weight[g]),
        .scaled_out(shifted[g*MANT_W +: MANT_W])
      );
    end
  endgenerate

  // Capture on the port strobe; idle ports hold their last value
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      scaled_q <= {4*MANT_W{1'b0}};
      scaled_valid_q <= 4'h0;
    end else begin
      for (q = 0; q < 4; q = q + 1) begin
        if (port_strobe[q] && sample_valid_in[q]) begin
          scaled_q[q*MANT_W +: MANT_W] <= shifted[q*MANT_W +: MANT_W];
        end
      end
      scaled_valid_q <= port_strobe & sample_valid_in;
    end
  end

  // Downstream filter sees only scaled data
  assign scaled_out = scaled_q;
  assign scaled_valid_out = scaled_valid_q;

endmodule

// ==== bench/input_exponent_scaler_asserts.sv ====
// Purpose: Port assertions for the input exponent scaler
// Assumes: One clock, synchronous active-high reset
// Notes: Per-port relations are checked on a sample of the ports
`timescale 1ns/1ps
module input_exponent_scaler_checker #(
  parameter MANT_W = 14
) (
  // Clock, strobes and samples
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire port_clock_ab_in,
  input wire port_clock_cd_in,
  input wire [4*MANT_W-1:0] mantissa_in,
  input wire [3:0] sample_valid_in,
  // Bus
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [31:0] wb_dat_out,
  input wire wb_ack_out,
  // Results
  input wire [4*MANT_W-1:0] scaled_out,
  input wire [3:0] scaled_valid_out,
  input wire [3:0] level_indicator_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_rdata_quiet: assert property (!wb_ack_out || $past(wb_we_in) |-> wb_dat_out == 32'h0)
    else $error("read data outside a read ack");
  a_valid_ab: assert property (port_clock_ab_in && sample_valid_in[0] |=> scaled_valid_out[0])
    else $error("port a sample lost");
  a_valid_cause_b: assert property (scaled_valid_out[1] |-> $past(port_clock_ab_in && sample_valid_in[1]))
    else $error("port b valid without sample");
  a_valid_cd: assert property (port_clock_cd_in && sample_valid_in[2] |=> scaled_valid_out[2])
    else $error("port c sample lost");
  a_valid_cause_d: assert property (scaled_valid_out[3] |-> $past(port_clock_cd_in && sample_valid_in[3]))
    else $error("port d valid without sample");
  a_hold_data: assert property (!scaled_valid_out[0] |-> $stable(scaled_out[MANT_W-1:0]))
    else $error("port a data moved without sample");
  a_sign_kept: assert property (scaled_valid_out[0] |-> scaled_out[MANT_W-1] == $past(mantissa_in[MANT_W-1]))
    else $error("port a sign lost");
  a_li_on_sample: assert property ($changed(level_indicator_out[0]) |-> $past(port_clock_ab_in && sample_valid_in[0]))
    else $error("indicator moved without sample");
  c_read: cover property (wb_ack_out && !$past(wb_we_in));
  c_li_set: cover property ($rose(level_indicator_out[0]));
  c_li_clear: cover property ($fell(level_indicator_out[0]));
endmodule
bind input_exponent_scaler input_exponent_scaler_checker #(.MANT_W(MANT_W)) chk_i (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .port_clock_ab_in(port_clock_ab_in),
  .port_clock_cd_in(port_clock_cd_in), .mantissa_in(mantissa_in),
  .sample_valid_in(sample_valid_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .scaled_out(scaled_out), .scaled_valid_out(scaled_valid_out),
  .level_indicator_out(level_indicator_out));

// ==== bench/converter_model.sv ====
// Purpose: Converter feeding the four input ports
// Assumes: Port strobes are pulses on the system clock
// Notes: Data changes every cycle, so stale data never looks valid
`timescale 1ns/1ps
module converter_model (
  // Control
  input wire clk_in,
  input wire run_in,
  input wire [3:0] bits_in,
  input wire fixed_in,
  // Converter lines
  output logic ab_out,
  output logic cd_out,
  output logic [55:0] mant_out,
  output logic [11:0] exp_out,
  output logic [3:0] valid_out
);
  logic [13:0] w;
  int p;
  initial begin
    ab_out = 1'b0;
    cd_out = 1'b0;
    mant_out = 56'h0;
    exp_out = 12'h0;
    valid_out = 4'h0;
  end
  // Strobes and valid flags come with random gaps
  always @(posedge clk_in) begin
    ab_out <= run_in && ($urandom % 4 != 0);
    cd_out <= run_in && ($urandom % 4 != 0);
    valid_out <= run_in ? 4'($urandom) : 4'h0;
    for (p = 0; p < 4; p++) begin
      w = 14'($urandom) & (14'h3fff << (4'he - bits_in)); // Low bits zero
      mant_out[p*14+:14] <= w;
      exp_out[p*3+:3] <= fixed_in ? 3'h0 : 3'($urandom);
    end
  end
endmodule

// ==== bench/test_input_exponent_scaler.sv ====
// Purpose: Self-checking bench for the input exponent scaler
// Assumes: Bus cycles by task, samples from the converter model
// Notes: Reference model runs on the falling edge, clear of the sampling edge
`timescale 1ns/1ps
module test_input_exponent_scaler;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, fixed = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] bits = 4'he, sel = 4'h0, vin, sv, liq;
  logic [11:0] adr = 12'h0, expo;
  logic [31:0] wdat = 32'h0, rd, rdat;
  logic [55:0] mant, sout;
  logic ab, cd, ack;
  logic [7:0] ctrl, c;
  logic [9:0] scale, s;
  logic [13:0] upper, lower;
  logic [15:0] dwell;
  logic [11:0] at[7] = '{12'h240, 12'h248, 12'h250, 12'h254, 12'h258, 12'h25c, 12'h3fc};
  logic [31:0] rt[7] = '{32'h0, 32'h0, 32'h1fff, 32'h1000, 32'h10, 32'h0, 32'h0};
  int n_fail = 0, num_checks = 0, i, p, m, mag, sh, sc;
  int li[4], cnt[4], ev[4], eo[4];
  input_exponent_scaler dut (.sys_clk_in(clk), .sys_rst_in(rst), .port_clock_ab_in(ab),
    .port_clock_cd_in(cd), .mantissa_in(mant), .exponent_in(expo), .sample_valid_in(vin),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .scaled_out(sout),
    .scaled_valid_out(sv), .level_indicator_out(liq));
  converter_model adc (.clk_in(clk), .run_in(run), .bits_in(bits), .fixed_in(fixed),
    .ab_out(ab), .cd_out(cd), .mant_out(mant), .exp_out(expo), .valid_out(vin));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One classic cycle; hold everything until ack is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Reference: compare last result, track writes, then predict the next edge
  always @(negedge clk) begin
    if (rst) begin
      ctrl = 8'h0;
      scale = 10'h0;
      upper = 14'h1fff;
      lower = 14'h1000;
      dwell = 16'h10;
      for (p = 0; p < 4; p++) begin
        li[p] = 0;
        cnt[p] = 0;
        ev[p] = 0;
      end
    end else begin
      for (p = 0; p < 4; p++) begin
        chk(sv[p], ev[p]);
        if (ev[p]) chk(sout[p*14+:14], eo[p] & 16'h3fff);
        chk(liq[p], li[p]);
      end
      if (ack && we) begin
        case (adr[11:2])
          10'h090: ctrl = wdat[7:0];
          10'h092: scale = wdat[9:0];
          10'h094: upper = wdat[13:0];
          10'h095: lower = wdat[13:0];
          10'h096: dwell = wdat[15:0];
          default: ;
        endcase
      end
      for (p = 0; p < 4; p++) begin
        ev[p] = (p < 2 ? ab : cd) & vin[p];
        if (ev[p]) begin
          m = $signed(mant[p*14+:14]);
          sc = li[p] ? scale[4:0] : scale[9:5];
          sh = (ctrl[p+4] ? 2 : 1) * expo[p*3+:3];
          sh = (ctrl[p] ? 7 - sh + sc : sh + sc) & 31;
          eo[p] = m >>> sh;
          mag = m < 0 ? -m : m;
          if (mag > 8191) mag = 8191;
          if (mag >= upper) begin
            li[p] = 1;
            cnt[p] = dwell;
          end else if (li[p]) begin
            if (mag >= lower) cnt[p] = dwell;
            else if (cnt[p] == 0) li[p] = 0;
            else cnt[p]--;
          end
        end
      end
    end
  end
  initial begin
    void'($urandom(28753));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      bus(1'b0, at[i], 32'h0);
      chk(rd, rt[i]);
    end
    for (i = 5; i < 7; i++) begin
      bus(1'b1, at[i], 32'hffffffff);
      bus(1'b0, at[i], 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b1, 12'h250, 32'h1000);
    bus(1'b1, 12'h254, 32'h800);
    bus(1'b1, 12'h258, 32'h2);
    // Settings change while samples keep flowing
    for (i = 0; i < 12; i++) begin
      fixed <= (i == 0);
      bits <= (i == 0) ? 4'he : 4'hb;
      c = 8'h0;
      s = 10'h0;
      if (i == 1) begin
        c = 8'h0f;
        s = {5'h1e, 5'h1e};
      end
      if (i == 2) c = 8'h0f;
      if (i > 2) begin
        c = 8'($urandom);
        s = 10'($urandom);
      end
      run <= 1'b1;
      bus(1'b1, 12'h240, {24'h0, c});
      bus(1'b1, 12'h248, {22'h0, s});
      bus(1'b0, 12'h248, 32'h0);
      chk(rd, {22'h0, s});
      repeat (300) @(posedge clk);
    end
    run <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, 12'h25c, 32'h0);
    chk(rd, 32'(li[0] + 2 * li[1] + 4 * li[2] + 8 * li[3]));
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
